// ---- hdl/ppf_pkg.sv ----
// constants, register map and bus types for the port pin function block
// assumes byte addresses on the register port, 16-bit write data
package ppf_pkg;

   localparam int REG_N = 11;

   // register indices
   localparam int R_P6_DATA = 0;
   localparam int R_P6_DIR = 1;
   localparam int R_P6_MODE = 2;
   localparam int R_P6_FUNC = 3;
   localparam int R_P6_PULL = 4;
   localparam int R_P7_DATA = 5;
   localparam int R_P7_DIR = 6;
   localparam int R_P8_DATA = 7;
   localparam int R_P8_DIR = 8;
   localparam int R_P8_MODE = 9;
   localparam int R_P8_PULL = 10;

   // byte address of the lower half; the upper half sits one above
   localparam logic [31:0] REG_BASE [0:REG_N-1] = '{
      32'hfffff40c, 32'hfffff42c, 32'hfffff44c, 32'hfffff46c, 32'hfffffc4c,
      32'hfffff40e, 32'hfffff42e, 32'hfffff410, 32'hfffff430, 32'hfffff450,
      32'hfffffc50};
   localparam logic [15:0] REG_MASK [0:REG_N-1] = '{
      16'hffff, 16'hffff, 16'h3c07, 16'h3c07, 16'hffff,
      16'hffff, 16'hffff, 16'h0003, 16'h0003, 16'h0003, 16'h0003};
   localparam logic [15:0] REG_RST [0:REG_N-1] = '{
      16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'hffff, 16'h0000, 16'h00ff, 16'h0000, 16'h0000};
   localparam logic REG_HALF_OK [0:REG_N-1] = '{
      1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
   localparam logic REG_HI_OK [0:REG_N-1] = '{
      1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

   // port 8 mode bits on the variant without the third uart
   localparam logic [15:0] P8_MODE_MASK_LITE = 16'h0001;

   // pin positions
   localparam int P6_INT_FIRST = 0;
   localparam int P6_INT_LAST = 2;
   localparam int P6_TMR_FIRST = 10;
   localparam int P6_TMR_LAST = 13;
   localparam int P8_RX_PIN = 0;
   localparam int P8_TX_PIN = 1;

   localparam int PIN_W = 34;

   typedef enum logic [1:0] {
      SZ_BYTE = 2'b00,
      SZ_HALF = 2'b01,
      SZ_BIT = 2'b10
   } ppf_size_e;

   typedef struct packed {
      logic [31:0] addr;
      logic [15:0] wdata;
      ppf_size_e size;
      logic [2:0] bitsel;
   } ppf_req_s;

endpackage : ppf_pkg

// ---- hdl/ppf_sync.sv ----
// two-flop synchroniser for the pin inputs
// assumes the pins are asynchronous to sys_clk
`timescale 1ns/100ps
module ppf_sync
   import ppf_pkg::*;
#(
   parameter int W = PIN_W
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   logic [W-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end

endmodule : ppf_sync

// ---- hdl/ppf_reg.sv ----
// one 16-bit control register with a mask of implemented bits
// assumes the caller has already merged byte and bit writes into d
`timescale 1ns/100ps
module ppf_reg
   import ppf_pkg::*;
#(
   parameter logic [15:0] RST = 16'h0000,
   parameter logic [15:0] MASK = 16'hffff
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wr,
   input wire logic [15:0] d,
   output logic [15:0] q
);

   logic [15:0] store;

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         store <= RST & MASK;
      end else if (wr) begin
         store <= d & MASK;
      end
   end

   // unimplemented bits read their fixed level
   assign q = store | (RST & ~MASK);

endmodule : ppf_reg

// ---- hdl/ppf_port_ctrl.sv ----
// direction and data control for ports 6, 7 and 8; pin function and pull-up control for ports 6 and 8 only
// assumes a single-cycle register port and pins synchronised inside
//
// What this block does
// - port6_function_select is a 16-bit register, word readable and writable
// - its upper and lower bytes are reachable by byte or bit access
// - control mode with function bit 0 leaves the pin output undefined
// - pins 10-13: function 0 is timer capture in, 1 compare out
// - pins 0-2: function 1 routes the pin to an external interrupt
// - a port 6 pull-up bit of 1 connects that pin's pull-up
// - port6_pullup_enable is 16 bits, word, byte or bit accessible
// - port 7 has sixteen pins with independent direction
// - port 7 data registers read pin levels and set output levels
// - port 7 data registers refuse 16-bit accesses
// - port 7 direction registers are byte or bit access only
// - port 8 has two pins with data, direction, mode and pull-up
// - port 8 pin 0 alternates as uart receive or interrupt, pin 1 transmit
// - without the third uart pin 0 is interrupt only, pin 1 none
// - a mode-control bit of 0 is port operation, 1 alternate function
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module ppf_port_ctrl
   import ppf_pkg::*;
#(
   parameter bit HAS_UART3 = 1'b1
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic [31:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic [1:0] bus_size,
   input wire logic [2:0] bus_bitsel,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [15:0] bus_rdata,
   input wire logic [15:0] p6_pin_in,
   output logic [15:0] p6_pin_out,
   output logic [15:0] p6_pin_oe,
   output logic [15:0] p6_pullup,
   input wire logic [15:0] p7_pin_in,
   output logic [15:0] p7_pin_out,
   output logic [15:0] p7_pin_oe,
   input wire logic [1:0] p8_pin_in,
   output logic [1:0] p8_pin_out,
   output logic [1:0] p8_pin_oe,
   output logic [1:0] p8_pullup,
   input wire logic [3:0] timer_q2_compare_out,
   output logic [3:0] timer_q2_capture_in,
   output logic ext_interrupt_11,
   output logic ext_interrupt_12,
   output logic ext_interrupt_13,
   output logic ext_interrupt_14,
   input wire logic uart3_transmit,
   output logic uart3_receive
);

   ppf_req_s req;
   logic [PIN_W-1:0] pin_s;
   logic [15:0] p6_s;
   logic [15:0] p7_s;
   logic [1:0] p8_s;
   logic [15:0] q [0:REG_N-1];
   logic [15:0] view [0:REG_N-1];
   logic [15:0] rd_acc [0:REG_N];
   logic [15:0] p6_lvl;
   logic [15:0] p7_lvl;
   logic [15:0] p8_lvl;
   logic [15:0] p6_mode;
   logic [15:0] p6_func;

   assign req = '{addr: bus_addr, wdata: bus_wdata,
                  size: ppf_size_e'(bus_size), bitsel: bus_bitsel};

   // merge a byte or bit write into the current value
   function automatic logic [15:0] merge(input logic [15:0] cur,
                                         input ppf_req_s r,
                                         input logic hi);
      logic [15:0] v;
      logic [3:0] idx;
      v = cur;
      idx = {hi, r.bitsel};
      case (r.size)
         SZ_HALF: v = r.wdata;
         SZ_BYTE: begin
            if (hi) begin
               v[15:8] = r.wdata[7:0];
            end else begin
               v[7:0] = r.wdata[7:0];
            end
         end
         SZ_BIT: v[idx] = r.wdata[0];
         default: v = cur;
      endcase
      return v;
   endfunction : merge

   // place a register view on the read data lanes
   function automatic logic [15:0] fmt(input logic [15:0] val,
                                       input ppf_req_s r,
                                       input logic hi);
      logic [15:0] v;
      logic [3:0] idx;
      v = 16'h0000;
      idx = {hi, r.bitsel};
      case (r.size)
         SZ_HALF: v = val;
         SZ_BYTE: v = {8'h00, hi ? val[15:8] : val[7:0]};
         SZ_BIT: v = {15'h0000, val[idx]};
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : fmt

   ppf_sync #(
      .W(PIN_W)
   ) u_sync (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .async_in({p8_pin_in, p7_pin_in, p6_pin_in}),
      .sync_out(pin_s)
   );

   assign p6_s = pin_s[15:0];
   assign p7_s = pin_s[31:16];
   assign p8_s = pin_s[33:32];

   // data reads show pin level on inputs, latch on outputs
   assign p6_lvl = (q[R_P6_DATA] & ~q[R_P6_DIR]) | (p6_s & q[R_P6_DIR]);
   assign p7_lvl = (q[R_P7_DATA] & ~q[R_P7_DIR]) | (p7_s & q[R_P7_DIR]);
   assign p8_lvl = (q[R_P8_DATA] & ~q[R_P8_DIR]) |
                   ({14'h0000, p8_s} & q[R_P8_DIR]);

   assign rd_acc[0] = 16'h0000;

   genvar gi;
   generate
      for (gi = 0; gi < REG_N; gi++) begin : g_reg
         localparam logic [15:0] MSK =
            (gi == R_P8_MODE && !HAS_UART3) ? P8_MODE_MASK_LITE : REG_MASK[gi];
         wire lo_hit = req.addr == REG_BASE[gi];
         wire hi_hit = REG_HI_OK[gi] && req.addr == REG_BASE[gi] + 32'h1;
         wire is_half = req.size == SZ_HALF;
         // word access only at the lower address of a 16-bit register
         wire sel = is_half ? (REG_HALF_OK[gi] && lo_hit) : (lo_hit || hi_hit);
         wire sel_hi = hi_hit && !is_half;
         wire [15:0] d = merge(q[gi], req, sel_hi);
         ppf_reg #(
            .RST(REG_RST[gi]),
            .MASK(MSK)
         ) u_reg (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .wr(bus_wr && sel),
            .d(d),
            .q(q[gi])
         );
         assign view[gi] = (gi == R_P6_DATA) ? p6_lvl :
                           (gi == R_P7_DATA) ? p7_lvl :
                           (gi == R_P8_DATA) ? p8_lvl : q[gi];
         assign rd_acc[gi+1] = rd_acc[gi] |
                               (sel ? fmt(view[gi], req, sel_hi) : 16'h0000);
      end
   endgenerate

   // read data stands for one cycle only, zero otherwise
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         bus_rdata <= 16'h0000;
      end else begin
         bus_rdata <= bus_rd ? rd_acc[REG_N] : 16'h0000;
      end
   end

   assign p6_mode = q[R_P6_MODE];
   assign p6_func = q[R_P6_FUNC];

   generate
      for (gi = 0; gi < 16; gi++) begin : g_p6
         wire alt_oe;
         wire alt_out;
         if (gi >= P6_TMR_FIRST && gi <= P6_TMR_LAST) begin : g_tmr
            assign alt_oe = p6_func[gi];
            assign alt_out = timer_q2_compare_out[gi-P6_TMR_FIRST];
            assign timer_q2_capture_in[gi-P6_TMR_FIRST] =
               p6_s[gi] & p6_mode[gi] & ~p6_func[gi];
         end else begin : g_in
            // interrupt pins are inputs; function 0 there is left undriven
            assign alt_oe = 1'b0;
            assign alt_out = 1'b0;
         end
         assign p6_pin_oe[gi] = p6_mode[gi] ? alt_oe : ~q[R_P6_DIR][gi];
         assign p6_pin_out[gi] = p6_mode[gi] ? alt_out : q[R_P6_DATA][gi];
      end
   endgenerate

   assign ext_interrupt_11 = p6_s[P6_INT_FIRST] & p6_mode[P6_INT_FIRST] &
                             p6_func[P6_INT_FIRST];
   assign ext_interrupt_12 = p6_s[P6_INT_FIRST+1] & p6_mode[P6_INT_FIRST+1] &
                             p6_func[P6_INT_FIRST+1];
   assign ext_interrupt_13 = p6_s[P6_INT_LAST] & p6_mode[P6_INT_LAST] &
                             p6_func[P6_INT_LAST];
   assign p6_pullup = q[R_P6_PULL];

   assign p7_pin_oe = ~q[R_P7_DIR];
   assign p7_pin_out = q[R_P7_DATA];

   // port 8: pin 0 is input in alternate mode, pin 1 drives uart transmit
   assign p8_pin_oe[P8_RX_PIN] = q[R_P8_MODE][P8_RX_PIN] ? 1'b0 :
                                 ~q[R_P8_DIR][P8_RX_PIN];
   assign p8_pin_out[P8_RX_PIN] = q[R_P8_MODE][P8_RX_PIN] ? 1'b0 :
                                  q[R_P8_DATA][P8_RX_PIN];
   assign p8_pin_oe[P8_TX_PIN] = q[R_P8_MODE][P8_TX_PIN] ? 1'b1 :
                                 ~q[R_P8_DIR][P8_TX_PIN];
   assign p8_pin_out[P8_TX_PIN] = q[R_P8_MODE][P8_TX_PIN] ? uart3_transmit :
                                  q[R_P8_DATA][P8_TX_PIN];
   assign ext_interrupt_14 = p8_s[P8_RX_PIN] & q[R_P8_MODE][P8_RX_PIN];
   assign uart3_receive = HAS_UART3 ? (p8_s[P8_RX_PIN] |
                                       ~q[R_P8_MODE][P8_RX_PIN]) : 1'b1;
   assign p8_pullup = q[R_P8_PULL][1:0];

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   wire wr_func_word = bus_wr && req.size == SZ_HALF &&
                       req.addr == REG_BASE[R_P6_FUNC];
   wire wr_func_hi = bus_wr && req.size == SZ_BYTE &&
                     req.addr == REG_BASE[R_P6_FUNC] + 32'h1;
   wire wr_pull_lo = bus_wr && req.size == SZ_BYTE &&
                     req.addr == REG_BASE[R_P6_PULL];
   wire wr_p7_word = bus_wr && req.size == SZ_HALF &&
                     (req.addr == REG_BASE[R_P7_DATA] ||
                      req.addr == REG_BASE[R_P7_DIR]);
   wire rd_p7_lo = bus_rd && req.size == SZ_BYTE &&
                   req.addr == REG_BASE[R_P7_DATA];
   wire wr_p7dir_lo = bus_wr && req.size == SZ_BYTE &&
                      req.addr == REG_BASE[R_P7_DIR];

   AST_FUNC_WORD: assert property (
      wr_func_word |=> p6_func == ($past(bus_wdata) & REG_MASK[R_P6_FUNC]))
      else $error("function select word write not stored");
   AST_FUNC_UPPER: assert property (
      wr_func_hi |=> p6_func[15:8] ==
         ($past(bus_wdata[7:0]) & REG_MASK[R_P6_FUNC][15:8]) &&
         p6_func[7:0] == $past(p6_func[7:0]))
      else $error("function select upper byte write wrong");
   AST_FUNC_RSVD: assert property (
      (p6_func & ~REG_MASK[R_P6_FUNC]) == 16'h0000)
      else $error("unimplemented function select bit set");
   AST_UNDEF_IN: assert property (
      p6_mode[P6_INT_FIRST] && !p6_func[P6_INT_FIRST] |->
         !p6_pin_oe[P6_INT_FIRST])
      else $error("interrupt pin driven with function 0");
   AST_TMR_OUT: assert property (
      p6_mode[P6_TMR_FIRST] && p6_func[P6_TMR_FIRST] |->
         p6_pin_oe[P6_TMR_FIRST] &&
         p6_pin_out[P6_TMR_FIRST] == timer_q2_compare_out[0])
      else $error("timer compare output not on pin");
   AST_INT_PATH: assert property (
      ext_interrupt_11 |-> p6_mode[P6_INT_FIRST] && p6_func[P6_INT_FIRST] &&
         $past(p6_pin_in[P6_INT_FIRST], 2))
      else $error("interrupt without its pin level");
   AST_PULL_LO: assert property (
      wr_pull_lo |=> p6_pullup[7:0] == $past(bus_wdata[7:0]))
      else $error("pull-up lower byte not applied");
   AST_P7_NO_WORD: assert property (
      wr_p7_word |=> $stable(q[R_P7_DATA]) && $stable(q[R_P7_DIR]))
      else $error("port 7 register took a word write");
   AST_P7_READ: assert property (
      rd_p7_lo |=> bus_rdata == {8'h00, $past(p7_lvl[7:0])})
      else $error("port 7 read does not show pin level");
   AST_P7_DIR: assert property (
      wr_p7dir_lo |=> p7_pin_oe[7:0] == ~$past(bus_wdata[7:0]))
      else $error("port 7 enable not from direction");
   AST_P8_TX: assert property (
      q[R_P8_MODE][P8_TX_PIN] |-> p8_pin_oe[P8_TX_PIN] &&
         p8_pin_out[P8_TX_PIN] == uart3_transmit)
      else $error("uart transmit not on port 8 pin 1");
   AST_P8_LITE: assert property (
      !HAS_UART3 |-> !q[R_P8_MODE][P8_TX_PIN])
      else $error("pin 1 alternate on reduced variant");
   AST_PORT_MODE: assert property (
      !p6_mode[P6_TMR_LAST] |-> p6_pin_oe[P6_TMR_LAST] ==
         !q[R_P6_DIR][P6_TMR_LAST])
      else $error("port mode pin not under direction");
   AST_P8_PORT: assert property (
      !q[R_P8_MODE][P8_RX_PIN] |->
         p8_pin_oe[P8_RX_PIN] == !q[R_P8_DIR][P8_RX_PIN] &&
         p8_pin_out[P8_RX_PIN] == q[R_P8_DATA][P8_RX_PIN])
      else $error("port 8 pin 0 not under its registers");
   AST_P6_PORT_OUT: assert property (
      !p6_mode[P6_INT_FIRST] |->
         p6_pin_out[P6_INT_FIRST] == q[R_P6_DATA][P6_INT_FIRST])
      else $error("port mode pin not driven from data");

   COV_TMR: cover property (wr_func_word ##1 p6_mode[P6_TMR_FIRST]);
   COV_INT: cover property (ext_interrupt_11);
   COV_P7_RD: cover property (rd_p7_lo);
   COV_P8_TX: cover property (q[R_P8_MODE][P8_TX_PIN]);
   COV_P7_DIR: cover property (wr_p7dir_lo);

endmodule : ppf_port_ctrl

// ---- verif/ppf_pins_model.sv ----
// board-side model of the port 6, 7 and 8 pins
// assumes the bench sets which pins an outside source drives, and how
`timescale 1ns/100ps
module ppf_pins_model (
   input wire logic sys_clk,
   input wire logic [15:0] p6_pin_out,
   input wire logic [15:0] p6_pin_oe,
   input wire logic [15:0] p6_pullup,
   input wire logic [15:0] p6_ext,
   input wire logic [15:0] p6_ext_en,
   input wire logic [15:0] p7_pin_out,
   input wire logic [15:0] p7_pin_oe,
   input wire logic [15:0] p7_ext,
   input wire logic [15:0] p7_ext_en,
   input wire logic [1:0] p8_pin_out,
   input wire logic [1:0] p8_pin_oe,
   input wire logic [1:0] p8_pullup,
   input wire logic [1:0] p8_ext,
   input wire logic [1:0] p8_ext_en,
   output logic [15:0] p6_pin_in,
   output logic [15:0] p7_pin_in,
   output logic [1:0] p8_pin_in
);
   logic tgl = 1'b0;
   logic [15:0] junk;
   logic [15:0] p8_wide;

   // floating pins with no pull-up wander every cycle
   always @(posedge sys_clk) tgl <= ~tgl;
   assign junk = 16'h5555 ^ {16{tgl}};

   function automatic logic [15:0] wire_lvl(input logic [15:0] o, oe, pl,
                                            x, xe, fl);
      return (oe & o) | (~oe & xe & x) | (~oe & ~xe & (pl | fl));
   endfunction : wire_lvl

   assign p6_pin_in = wire_lvl(p6_pin_out, p6_pin_oe, p6_pullup, p6_ext,
                               p6_ext_en, junk);
   assign p7_pin_in = wire_lvl(p7_pin_out, p7_pin_oe, 16'h0000, p7_ext,
                               p7_ext_en, junk);
   assign p8_wide = wire_lvl({14'h0, p8_pin_out}, {14'h0, p8_pin_oe},
      {14'h0, p8_pullup}, {14'h0, p8_ext}, {14'h0, p8_ext_en}, junk);
   assign p8_pin_in = p8_wide[1:0];
endmodule : ppf_pins_model

// ---- verif/tb_top.sv ----
// self-checking bench for the port pin function block
// assumes the pin model in ppf_pins_model; tb plays timer and uart
`timescale 1ns/100ps
module tb_top;
   import ppf_pkg::*;
   localparam logic [31:0] A_FN = REG_BASE[R_P6_FUNC];
   localparam logic [31:0] A_MD = REG_BASE[R_P6_MODE];
   localparam logic [31:0] A_PU = REG_BASE[R_P6_PULL];
   localparam logic [31:0] A_7D = REG_BASE[R_P7_DATA];
   localparam logic [31:0] A_7M = REG_BASE[R_P7_DIR];
   logic sys_clk, sys_rst, bus_wr, bus_rd, uart3_transmit, uart3_receive;
   logic ext_interrupt_11, ext_interrupt_12, ext_interrupt_13;
   logic ext_interrupt_14;
   logic [31:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, p6_pin_in, p6_pin_out, p6_pin_oe;
   logic [15:0] p6_pullup, p7_pin_in, p7_pin_out, p7_pin_oe;
   logic [15:0] p6_ext, p6_ext_en, p7_ext, p7_ext_en;
   logic [1:0] bus_size, p8_pin_in, p8_pin_out, p8_pin_oe, p8_pullup;
   logic [1:0] p8_ext, p8_ext_en;
   logic [2:0] bus_bitsel;
   logic [3:0] timer_q2_compare_out, timer_q2_capture_in;
   int num_errors = 0;
   int checked = 0;

   ppf_port_ctrl dut_u (.sys_clk, .sys_rst, .bus_addr, .bus_wdata,
      .bus_size, .bus_bitsel, .bus_wr, .bus_rd, .bus_rdata, .p6_pin_in,
      .p6_pin_out, .p6_pin_oe, .p6_pullup, .p7_pin_in, .p7_pin_out,
      .p7_pin_oe, .p8_pin_in, .p8_pin_out, .p8_pin_oe, .p8_pullup,
      .timer_q2_compare_out, .timer_q2_capture_in, .ext_interrupt_11,
      .ext_interrupt_12, .ext_interrupt_13, .ext_interrupt_14,
      .uart3_transmit, .uart3_receive);
   ppf_pins_model pins_u (.sys_clk, .p6_pin_out, .p6_pin_oe, .p6_pullup,
      .p6_ext, .p6_ext_en, .p7_pin_out, .p7_pin_oe, .p7_ext, .p7_ext_en,
      .p8_pin_out, .p8_pin_oe, .p8_pullup, .p8_ext, .p8_ext_en, .p6_pin_in,
      .p7_pin_in, .p8_pin_in);

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end

   task automatic check(input string what, input logic [15:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [31:0] a, input logic [15:0] d,
                     input ppf_size_e sz, input logic [2:0] b);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_size <= sz;
      bus_bitsel <= b;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      #1;
   endtask : wr

   task automatic rd_chk(input string what, input logic [31:0] a,
                         input ppf_size_e sz, input logic [15:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_size <= sz;
      bus_bitsel <= 3'h0;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1;
      check(what, bus_rdata, exp);
   endtask : rd_chk

   // pin levels cross two sync flops before they are seen
   task automatic settle();
      repeat (3) @(posedge sys_clk);
      #1;
   endtask : settle

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish

   task automatic sc_reset();
      rd_chk("func reset", A_FN, SZ_HALF, 16'h0000);
      rd_chk("pullup reset", A_PU, SZ_HALF, 16'h0000);
      rd_chk("p7 dir hi reset", A_7M + 1, SZ_BYTE, 16'h00ff);
      @(posedge sys_clk);
      #1;
      check("rdata idle", bus_rdata, 16'h0000);
      check("p7 oe reset", p7_pin_oe, 16'h0000);
      $display("done sc_reset");
   endtask : sc_reset

   task automatic sc_func();
      wr(A_FN, 16'hffff, SZ_HALF, 3'h0);
      rd_chk("func word", A_FN, SZ_HALF, REG_MASK[R_P6_FUNC]);
      rd_chk("func upper", A_FN + 1, SZ_BYTE,
             {8'h00, REG_MASK[R_P6_FUNC][15:8]});
      wr(A_FN + 1, 16'h0000, SZ_BIT, 3'h5);
      rd_chk("func bit13", A_FN, SZ_HALF,
             REG_MASK[R_P6_FUNC] & 16'hdfff);
      wr(A_FN, 16'h0000, SZ_HALF, 3'h0);
      rd_chk("func cleared", A_FN, SZ_HALF, 16'h0000);
      $display("done sc_func");
   endtask : sc_func

   task automatic sc_pull();
      wr(A_PU, 16'ha5c3, SZ_HALF, 3'h0);
      check("pullup pins", p6_pullup, 16'ha5c3);
      rd_chk("pullup upper", A_PU + 1, SZ_BYTE, 16'h00a5);
      rd_chk("pullup bit8 rd", A_PU + 1, SZ_BIT, 16'h0001);
      wr(A_PU + 1, 16'h0000, SZ_BIT, 3'h0);
      check("pullup bit8", p6_pullup, 16'ha4c3);
      $display("done sc_pull");
   endtask : sc_pull

   task automatic sc_p7();
      wr(A_7D, 16'h5a5a, SZ_HALF, 3'h0);
      check("p7 word ignored", p7_pin_out, 16'h0000);
      rd_chk("p7 data word", A_7D, SZ_HALF, 16'h0000);
      wr(A_7D, 16'h005a, SZ_BYTE, 3'h0);
      wr(A_7M, 16'h0000, SZ_BYTE, 3'h0);
      wr(A_7M, 16'h0000, SZ_HALF, 3'h0);
      check("p7 oe", p7_pin_oe, 16'h00ff);
      check("p7 out", {8'h00, p7_pin_out[7:0]}, 16'h005a);
      rd_chk("p7 data lo", A_7D, SZ_BYTE, 16'h005a);
      rd_chk("p7 dir word", A_7M, SZ_HALF, 16'h0000);
      p7_ext <= 16'h3c00;
      p7_ext_en <= 16'hff00;
      settle();
      rd_chk("p7 data hi", A_7D + 1, SZ_BYTE, 16'h003c);
      $display("done sc_p7");
   endtask : sc_p7

   task automatic sc_port();
      wr(REG_BASE[R_P6_DIR], 16'h0ff0, SZ_HALF, 3'h0);
      wr(REG_BASE[R_P6_DATA], 16'h1234, SZ_HALF, 3'h0);
      check("p6 oe port", p6_pin_oe, 16'hf00f);
      check("p6 out port", p6_pin_out, 16'h1234);
      wr(REG_BASE[R_P8_DIR], 16'h00fe, SZ_BYTE, 3'h0);
      wr(REG_BASE[R_P8_DATA], 16'h0001, SZ_BYTE, 3'h0);
      rd_chk("p8 dir", REG_BASE[R_P8_DIR], SZ_BYTE, 16'h00fe);
      check("p8 port", {12'h0, p8_pin_oe, p8_pin_out}, 16'h5);
      wr(REG_BASE[R_P6_DIR], 16'hffff, SZ_HALF, 3'h0);
      $display("done sc_port");
   endtask : sc_port

   task automatic sc_timer();
      timer_q2_compare_out <= 4'ha;
      wr(A_FN + 1, 16'h003c, SZ_BYTE, 3'h0);
      wr(A_MD + 1, 16'h003c, SZ_BYTE, 3'h0);
      check("tmr oe", {12'h0, p6_pin_oe[13:10]}, 16'h000f);
      check("tmr out", {12'h0, p6_pin_out[13:10]}, 16'h000a);
      wr(A_FN + 1, 16'h0000, SZ_BYTE, 3'h0);
      p6_ext[13:10] <= 4'h6;
      p6_ext_en[13:10] <= 4'hf;
      settle();
      check("capture", {12'h0, timer_q2_capture_in}, 16'h6);
      wr(A_MD + 1, 16'h0000, SZ_BYTE, 3'h0);
      check("capture off", {12'h0, timer_q2_capture_in}, 16'h0);
      $display("done sc_timer");
   endtask : sc_timer

   task automatic sc_intr();
      wr(A_FN, 16'h0007, SZ_BYTE, 3'h0);
      wr(A_MD, 16'h0007, SZ_BYTE, 3'h0);
      p6_ext[2:0] <= 3'b101;
      p6_ext_en[2:0] <= 3'b111;
      settle();
      check("int a", {13'h0, ext_interrupt_13, ext_interrupt_12,
            ext_interrupt_11}, 16'h0005);
      p6_ext[2:0] <= 3'b010;
      settle();
      check("int b", {13'h0, ext_interrupt_13, ext_interrupt_12,
            ext_interrupt_11}, 16'h0002);
      $display("done sc_intr");
   endtask : sc_intr

   task automatic sc_p8();
      uart3_transmit <= 1'b1;
      p8_ext_en <= 2'b01;
      p8_ext <= 2'b00;
      wr(REG_BASE[R_P8_MODE], 16'h0003, SZ_BYTE, 3'h0);
      wr(REG_BASE[R_P8_PULL], 16'h0002, SZ_BYTE, 3'h0);
      settle();
      check("p8 tx", {14'h0, p8_pin_oe[1], p8_pin_out[1]},
            16'h3);
      check("p8 rx", {14'h0, uart3_receive, ext_interrupt_14},
            16'h0);
      check("p8 pull", {14'h0, p8_pullup}, 16'h0002);
      p8_ext <= 2'b01;
      uart3_transmit <= 1'b0;
      settle();
      check("p8 rx hi", {14'h0, uart3_receive, ext_interrupt_14},
            16'h3);
      check("p8 tx low", {15'h0, p8_pin_out[1]}, 16'h0);
      $display("done sc_p8");
   endtask : sc_p8

   initial begin
      sys_rst = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 32'h0;
      bus_wdata = 16'h0;
      bus_size = 2'h0;
      bus_bitsel = 3'h0;
      uart3_transmit = 1'b1;
      timer_q2_compare_out = 4'h0;
      p6_ext = 16'h0;
      p6_ext_en = 16'h0;
      p7_ext = 16'h0;
      p7_ext_en = 16'h0;
      p8_ext = 2'h0;
      p8_ext_en = 2'h0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 1'b0;
      sc_reset();
      sc_func();
      sc_pull();
      sc_p7();
      sc_port();
      sc_timer();
      sc_intr();
      sc_p8();
      tally_and_finish();
   end

   initial begin
      #40000;
      num_errors++;
      tally_and_finish();
   end
endmodule : tb_top
